// ### asrc_control.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - a channel enters soft reset only when its reset bit is set by software and leaves when it is cleared.
// - while in soft reset the converter keeps running but every presented result is forced to zero.
// - entering or leaving soft reset never alters the phase, interrupt mask or shutdown register contents.
// - after leaving soft reset results become meaningful only after three output-rate periods of settling.
// - each channel enters and leaves soft reset independently of the other.
// - no data-ready pulse is produced for a channel while it is in soft reset.
// - an enabled modulator output of a channel in soft reset repeats the zero-level pattern 0011.
// - the configured phase delay still applies after a channel leaves soft reset.
// - a returning channel realigns to the running channel by the phase delay and then pulses on that schedule.
// - resetting one channel while the other converts keeps the internal clock running.
// - the digital core clock enable drops when both channels are in soft reset or shutdown.
// - in normal operation each new result is signalled by a pulse on the active-low data-ready output.
// - shutdown is entered only by shutdown bits, flushes data to zero and suppresses data-ready pulses.
module asrc_control #(
    parameter int RESULT_W = asrc_pkg::RESULT_W,
    parameter int PHASE_W = asrc_pkg::PHASE_W
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    input wire logic output_rate_clock_i,
    input wire logic [1:0] conv_done_i,
    input wire logic [RESULT_W-1:0] conv_data0_i,
    input wire logic [RESULT_W-1:0] conv_data1_i,
    input wire logic [1:0] mod_enable_i,
    input wire logic [1:0] mod_bit_i,
    output logic [1:0] result_ready_n_o,
    output logic [1:0] modulator_bitstream_out_o,
    output logic core_clock_en_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] rst_reg;
    logic [1:0] shdn_reg;
    logic [PHASE_W-1:0] phase_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rdy_n_reg;
    logic [1:0] mod_reg;
    logic [1:0] pat_idx_reg [asrc_pkg::NUM_CH];
    logic [RESULT_W-1:0] data_reg [asrc_pkg::NUM_CH];
    asrc_pkg::asrc_state_type state_reg [asrc_pkg::NUM_CH];
    asrc_pkg::asrc_state_type state_next [asrc_pkg::NUM_CH];
    logic [PHASE_W-1:0] align_cnt_reg [asrc_pkg::NUM_CH];
    logic [1:0] settle_cnt_reg [asrc_pkg::NUM_CH];
    logic rate_d_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic wr_rst = wr_i && (addr_i == asrc_pkg::OFF_RESET);
    wire logic wr_shdn = wr_i && (addr_i == asrc_pkg::OFF_SHDN);
    wire logic wr_phase = wr_i && (addr_i == asrc_pkg::OFF_PHASE);
    wire logic wr_mask = wr_i && (addr_i == asrc_pkg::OFF_IRQ_MASK);
    wire logic rd_stat = rd_i && (addr_i == asrc_pkg::OFF_IRQ_STAT);
    wire logic rate_tick = output_rate_clock_i && !rate_d_reg;
    // a channel is held when reset or shut down
    wire logic [1:0] held = rst_reg | shdn_reg;

    function automatic logic [31:0] widen(input logic [RESULT_W-1:0] v);
        widen = 32'(v);
    endfunction

    // a channel only takes results once it is back on the running schedule
    function automatic logic running(input asrc_pkg::asrc_state_type s, input logic h);
        running = (s == asrc_pkg::ASRC_RUN) && !h;
    endfunction

    // bit of the zero-level pattern for a pattern index, msb first
    function automatic logic zero_bit(input logic [1:0] idx);
        zero_bit = asrc_pkg::ZERO_PATTERN[2'h3 - idx];
    endfunction

    // both channels decoded up front, so the sequencer never reads its own outputs
    wire logic [1:0] ch_run = {running(state_reg[1], held[1]), running(state_reg[0], held[0])};
    // no result or pulse while held or settling
    wire logic [1:0] new_result = conv_done_i & ch_run;

    // ------------------------------------------------------------
    // per-channel sequencing
    // ------------------------------------------------------------
    // the other channel is only a timing reference while it runs
    always_comb begin
        for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
            state_next[c] = state_reg[c];
            case (state_reg[c])
                asrc_pkg::ASRC_RUN: begin
                    if (held[c]) begin
                        state_next[c] = asrc_pkg::ASRC_HELD;
                    end
                end
                asrc_pkg::ASRC_HELD: begin
                    if (!held[c]) begin
                        state_next[c] = ch_run[1-c] ? asrc_pkg::ASRC_ALIGN : asrc_pkg::ASRC_SETTLE;
                    end
                end
                asrc_pkg::ASRC_ALIGN: begin
                    if (held[c]) begin
                        state_next[c] = asrc_pkg::ASRC_HELD;
                    end else if (align_cnt_reg[c] == '0) begin
                        state_next[c] = asrc_pkg::ASRC_SETTLE;
                    end
                end
                asrc_pkg::ASRC_SETTLE: begin
                    if (held[c]) begin
                        state_next[c] = asrc_pkg::ASRC_HELD;
                    end else if (rate_tick && settle_cnt_reg[c] == 2'(asrc_pkg::SETTLE_PERIODS - 1)) begin
                        state_next[c] = asrc_pkg::ASRC_RUN;
                    end
                end
                default: state_next[c] = asrc_pkg::ASRC_HELD;
            endcase
        end
    end

    // core clock stays on while either channel is active
    assign core_clock_en_o = ~(held[0] & held[1]);

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // mode bits change only on software writes, never by the mode itself
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_reg <= asrc_pkg::RST_FIELD_RESET;
            shdn_reg <= asrc_pkg::SHDN_FIELD_RESET;
        end else begin
            if (wr_rst) rst_reg <= wdata_i[1:0];
            if (wr_shdn) shdn_reg <= wdata_i[1:0];
        end
    end

    // the delay survives any trip through soft reset or shutdown
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_reg <= PHASE_W'(asrc_pkg::PHASE_RESET);
            irq_mask_reg <= asrc_pkg::IRQ_MASK_RESET;
        end else begin
            if (wr_phase) phase_reg <= wdata_i[PHASE_W-1:0];
            if (wr_mask) irq_mask_reg <= wdata_i[1:0];
        end
    end

    // set wins over the read-clear
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= (rd_stat ? 2'h0 : irq_stat_reg) | new_result;
        end
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    // a held channel reads zero from its first held cycle, not one later
    wire logic [RESULT_W-1:0] shown_data0 = held[0] ? '0 : data_reg[0];
    wire logic [RESULT_W-1:0] shown_data1 = held[1] ? '0 : data_reg[1];
    wire logic [31:0] rd_mux =
        (addr_i == asrc_pkg::OFF_RESET) ? {30'h0, rst_reg} :
        (addr_i == asrc_pkg::OFF_SHDN) ? {30'h0, shdn_reg} :
        (addr_i == asrc_pkg::OFF_PHASE) ? 32'(phase_reg) :
        (addr_i == asrc_pkg::OFF_STATUS) ? {28'h0, state_reg[1], state_reg[0]} :
        (addr_i == asrc_pkg::OFF_IRQ_STAT) ? {30'h0, irq_stat_reg} :
        (addr_i == asrc_pkg::OFF_IRQ_MASK) ? {30'h0, irq_mask_reg} :
        (addr_i == asrc_pkg::OFF_DATA0) ? widen(shown_data0) :
        (addr_i == asrc_pkg::OFF_DATA1) ? widen(shown_data1) : 32'h0;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rd_i ? rd_mux : 32'h0;
        end
    end
    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // channel datapath
    // ------------------------------------------------------------
    wire logic [RESULT_W-1:0] conv_data [asrc_pkg::NUM_CH];
    assign conv_data[0] = conv_data0_i;
    assign conv_data[1] = conv_data1_i;

    // a held and enabled output plays the zero pattern in place of the modulator
    wire logic [1:0] pat_bits = {zero_bit(pat_idx_reg[1]), zero_bit(pat_idx_reg[0])};
    wire logic [1:0] mod_next = mod_enable_i & ((held & pat_bits) | (~held & mod_bit_i));

    // output-rate edges are found in the core clock domain
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rate_d_reg <= 1'b0;
        end else begin
            rate_d_reg <= output_rate_clock_i;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                state_reg[c] <= asrc_pkg::ASRC_RUN;
            end
        end else begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                state_reg[c] <= state_next[c];
            end
        end
    end

    // realign against the running channel by the stored delay
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                align_cnt_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                if (state_reg[c] == asrc_pkg::ASRC_HELD) begin
                    align_cnt_reg[c] <= phase_reg;
                end else if (align_cnt_reg[c] != '0) begin
                    align_cnt_reg[c] <= align_cnt_reg[c] - 1'b1;
                end
            end
        end
    end

    // settling only counts output-rate edges seen while settling
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                settle_cnt_reg[c] <= 2'h0;
            end
        end else begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                if (state_reg[c] != asrc_pkg::ASRC_SETTLE) begin
                    settle_cnt_reg[c] <= 2'h0;
                end else if (rate_tick) begin
                    settle_cnt_reg[c] <= settle_cnt_reg[c] + 2'h1;
                end
            end
        end
    end

    // results flushed to zero while held
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                data_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                if (held[c]) begin
                    data_reg[c] <= '0;
                end else if (new_result[c]) begin
                    data_reg[c] <= conv_data[c];
                end
            end
        end
    end

    // index restarts on every entry, so the pattern always opens with its zeros
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                pat_idx_reg[c] <= 2'h0;
            end
        end else begin
            for (int c = 0; c < asrc_pkg::NUM_CH; c++) begin
                pat_idx_reg[c] <= held[c] ? pat_idx_reg[c] + 2'h1 : 2'h0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdy_n_reg <= 2'h3;
            mod_reg <= 2'h0;
        end else begin
            rdy_n_reg <= ~new_result;
            mod_reg <= mod_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign result_ready_n_o = rdy_n_reg;
    assign modulator_bitstream_out_o = mod_reg;
endmodule // asrc_control

`default_nettype wire

// ### asrc_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_control_asserts (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] conv_done_i,
    input wire logic [1:0] mod_enable_i,
    input wire logic [1:0] result_ready_n_o,
    input wire logic [1:0] modulator_bitstream_out_o,
    input wire logic core_clock_en_o
);
    logic [1:0] rst_reg;
    logic [1:0] shdn_reg;
    wire logic [1:0] held = rst_reg | shdn_reg;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // ----
    // hold fields mirrored from the bus, so no internal probes are needed
    // ----
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_reg <= 2'h0;
            shdn_reg <= 2'h0;
        end else if (wr_i && addr_i == asrc_pkg::OFF_RESET) begin
            rst_reg <= wdata_i[1:0];
        end else if (wr_i && addr_i == asrc_pkg::OFF_SHDN) begin
            shdn_reg <= wdata_i[1:0];
        end
    end
    ready_cause_a: assert property ((~result_ready_n_o & ~$past(conv_done_i)) == 2'h0)
        else $error("ready pulse without result");
    held_quiet_a: assert property ((~result_ready_n_o & held & $past(held) & $past(held, 2)) == 2'h0)
        else $error("ready pulse while held");
    clock_gate_a: assert property (core_clock_en_o == !(&held))
        else $error("core clock enable wrong");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    held_data_a: assert property (rd_i && addr_i == asrc_pkg::OFF_DATA0 && held[0] |=> rdata_o == 32'h0)
        else $error("held channel data not zero");
    unmapped_zero_a: assert property (rd_i && addr_i > asrc_pkg::OFF_DATA1 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    zero_pattern_a: assert property (held[0] && $past(held[0], 6) |-> modulator_bitstream_out_o[0] != $past(modulator_bitstream_out_o[0], 2))
        else $error("zero pattern broken");
    mod_off_a: assert property (!$past(mod_enable_i[1]) |-> !modulator_bitstream_out_o[1])
        else $error("disabled modulator output active");
endmodule // asrc_control_asserts
bind asrc_control asrc_control_asserts asrc_control_asserts_inst (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .conv_done_i, .mod_enable_i, .result_ready_n_o, .modulator_bitstream_out_o, .core_clock_en_o);
`default_nettype wire

// ### asrc_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_control_tb_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] mod_enable_i = 2'h3;
    logic [31:0] rdata_o;
    logic irq_o;
    logic rate;
    logic [1:0] done;
    logic [23:0] data;
    logic [1:0] mbit;
    logic [1:0] rdy_n;
    logic [1:0] mod_out;
    logic clk_en;
    int miscompares = 0;
    int compares = 0;
    int rises;
    logic [7:0] pat;
    always #20 clock_i = ~clock_i;
    asrc_conv_model asrc_conv_model_inst (.clock_i, .nrst_i, .rate_o(rate), .done_o(done), .data_o(data), .bit_o(mbit));
    asrc_control asrc_control_inst (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
        .output_rate_clock_i(rate), .conv_done_i(done), .conv_data0_i(data), .conv_data1_i(data), .mod_enable_i,
        .mod_bit_i(mbit), .result_ready_n_o(rdy_n), .modulator_bitstream_out_o(mod_out), .core_clock_en_o(clk_en));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 check(rdata_o & m, e);
    endtask
    // counts output-rate rising edges while waiting for a ready pulse
    task wait_rdy(input int c);
        logic prev;
        rises = 0;
        for (int n = 0; rdy_n[c] !== 1'b0; n++) begin
            if (n > 300) begin
                miscompares++;
                test_done;
            end
            prev = rate;
            @(posedge clock_i);
            #1 rises += int'(rate && !prev);
        end
    endtask
    initial begin
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(4'(i), 32'h0);
        end
        wr(asrc_pkg::OFF_PHASE, 32'h5);
        wr(asrc_pkg::OFF_RESET, 32'h1);
        wait_rdy(1);
        check(32'(clk_en), 32'h1);
        rd(asrc_pkg::OFF_DATA0, 32'h0);
        rd(asrc_pkg::OFF_STATUS, 32'h1, 32'hF);
        rd(asrc_pkg::OFF_PHASE, 32'h5);
        check(32'(irq_o), 32'h0);
        wr(asrc_pkg::OFF_IRQ_MASK, 32'h2);
        check(32'(irq_o), 32'h1);
        wr(asrc_pkg::OFF_RESET, 32'h3);
        check(32'(clk_en), 32'h0);
        // channel one is newly held: pattern opens at index zero, one cycle late
        pat = 8'h0;
        repeat (8) begin
            @(posedge clock_i);
            #1 pat = {pat[6:0], mod_out[1]};
        end
        check(32'(pat), 32'h33);
        rd(asrc_pkg::OFF_IRQ_STAT, 32'h2, 32'h2);
        rd(asrc_pkg::OFF_IRQ_STAT, 32'h0);
        check(32'(irq_o), 32'h0);
        wr(asrc_pkg::OFF_SHDN, 32'h1);
        wr(asrc_pkg::OFF_RESET, 32'h0);
        check(32'(clk_en), 32'h1);
        rd(asrc_pkg::OFF_STATUS, 32'h1, 32'h3);
        wait_rdy(1);
        wr(asrc_pkg::OFF_SHDN, 32'h0);
        rd(asrc_pkg::OFF_STATUS, 32'h2, 32'h3);
        wait_rdy(0);
        check(32'(rises >= 3), 32'h1);
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0);
        @(posedge clock_i);
        mod_enable_i <= 2'h1;
        rd(asrc_pkg::OFF_PHASE, 32'h5);
        @(posedge clock_i);
        nrst_i <= 1'b0;
        @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(asrc_pkg::OFF_PHASE, 32'(asrc_pkg::PHASE_RESET));
        test_done;
    end
endmodule // asrc_control_tb_top
`default_nettype wire

// ### asrc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module asrc_conv_model (
    input wire logic clock_i,
    input wire logic nrst_i,
    output logic rate_o,
    output logic [1:0] done_o,
    output logic [23:0] data_o,
    output logic [1:0] bit_o
);
    logic [3:0] tick_reg;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_reg <= 4'h0;
        end else begin
            tick_reg <= tick_reg + 4'h1;
        end
    end
    // converters never stop, so a held channel still gets results
    assign done_o = {tick_reg == 4'hC, tick_reg == 4'h4};
    assign rate_o = tick_reg[3];
    assign data_o = {20'h0, tick_reg} + 24'h1;
    assign bit_o = tick_reg[1:0];
endmodule // asrc_conv_model
`default_nettype wire

// ### asrc_pkg.sv
package asrc_pkg;
    // channel reset / shutdown field layout
    localparam int NUM_CH = 2;
    localparam int CH0_BIT = 0;
    localparam int CH1_BIT = 1;
    localparam logic [1:0] RST_FIELD_RESET = 2'h0;
    localparam logic [1:0] SHDN_FIELD_RESET = 2'h0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    // modulator zero-level pattern, sent msb first
    localparam logic [3:0] ZERO_PATTERN = 4'h3;
    localparam int SETTLE_PERIODS = 3;
    localparam int RESULT_W = 24;
    localparam int PHASE_W = 8;
    // register offsets of the plain port
    localparam logic [3:0] OFF_RESET = 4'h0;
    localparam logic [3:0] OFF_SHDN = 4'h1;
    localparam logic [3:0] OFF_PHASE = 4'h2;
    localparam logic [3:0] OFF_STATUS = 4'h3;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h5;
    localparam logic [3:0] OFF_DATA0 = 4'h6;
    localparam logic [3:0] OFF_DATA1 = 4'h7;

    typedef struct packed {
        logic valid;
        logic [RESULT_W-1:0] value;
    } asrc_result_type;

    typedef enum logic [1:0] {
        ASRC_RUN = 2'b00,
        ASRC_HELD = 2'b01,
        ASRC_ALIGN = 2'b10,
        ASRC_SETTLE = 2'b11
    } asrc_state_type;
endpackage
